// ===== core/arf_pkg.sv
/*
  Constants of the host-side API output framer: frame layout offsets,
  frame type codes, option masks, status codes and reset values.
  Assumes one 10 MHz clock and nothing else from its surroundings.
*/
// ****************************************************************
// Framer package
// ****************************************************************
package arf_pkg;
  // Framing bytes
  localparam logic [7:0] START_DELIM = 8'h7E;
  localparam logic [7:0] SUM_SEED = 8'hFF;
  // Frame type codes
  localparam logic [7:0] TYPE_RX64 = 8'h80;
  localparam logic [7:0] TYPE_AT_RESP = 8'h88;
  localparam logic [7:0] TYPE_AT_REQ = 8'h08;
  localparam logic [7:0] TYPE_AT_QUEUED = 8'h09;
  // Receive gating values
  localparam logic [7:0] OUTPUT_OPTION_LEGACY = 8'h02;
  localparam logic [15:0] SHORT_ADDR_NONE = 16'hFFFE;
  // Byte offsets within a frame
  localparam logic [4:0] OFS_LEN_HI = 5'h01;
  localparam logic [4:0] OFS_LEN_LO = 5'h02;
  localparam logic [4:0] OFS_TYPE = 5'h03;
  localparam logic [4:0] OFS_SRC_FIRST = 5'h04;
  localparam logic [4:0] OFS_SRC_LAST = 5'h0B;
  localparam logic [4:0] OFS_RSSI = 5'h0C;
  localparam logic [4:0] OFS_OPTIONS = 5'h0D;
  localparam logic [4:0] OFS_FRAME_ID = 5'h04;
  localparam logic [4:0] OFS_CMD_HI = 5'h05;
  localparam logic [4:0] OFS_CMD_LO = 5'h06;
  localparam logic [4:0] OFS_STATUS = 5'h07;
  // Fixed bytes between length and payload, per frame kind
  localparam logic [15:0] RX_FIXED_LEN = 16'h000B;
  localparam logic [15:0] AT_FIXED_LEN = 16'h0005;
  // Option bits of a receive frame
  localparam logic [7:0] OPT_BROADCAST = 8'h02;
  localparam logic [7:0] OPT_ALL_NETWORKS = 8'h04;
  // Command status codes
  localparam logic [1:0] STATUS_OK = 2'h0;
  localparam logic [1:0] STATUS_ERROR = 2'h1;
  localparam logic [1:0] STATUS_BAD_CMD = 2'h2;
  localparam logic [1:0] STATUS_BAD_PARAM = 2'h3;
  // Reset values
  localparam logic [4:0] IDX_RESET = 5'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_HEAD = 4'b0010,
    ST_PAYLOAD = 4'b0100,
    ST_SUM = 4'b1000
  } arf_state_t;
endpackage

// ===== core/arf_framer.sv
/*
  Output frame builder for the host serial API: legacy 64-bit receive
  frames and local command response frames, each with start byte,
  length and checksum, sent one byte at a time with valid/ready.
  Assumes request fields and payload bytes come from logic on the same
  clock, that payload bytes answer a pull strobe, and that escaping is
  done downstream.
*/

// Functional notes
// - Length field counts bytes between length and checksum
// - Checksum is FF minus sum from type on
// - Receive frame only in legacy mode, unshort sender
// - Sender long address at offset four
// - Signal strength magnitude at offset twelve
// - Option bits byte at offset thirteen
// - Received payload copied in order from fourteen
// - Command response answers plain or queued request
// - No response when request frame id zero
// - Request frame id echoed at offset four
// - Two command characters echoed at offset five
// - Status byte at offset seven, codes 0-3
// - Data only after a query, from offset eight
// - Several responses allowed for one request; the framer sends one frame per started request, none for a refused one
module arf_framer (
  input wire logic i_clock,
  input wire logic i_reset_n,
  // Configuration
  input wire logic [7:0] i_api_output_option,
  // Receive packet request
  input wire logic i_rx_start,
  input wire logic [63:0] i_rx_src_addr,
  input wire logic [15:0] i_rx_own_short_address,
  input wire logic [7:0] i_rx_rssi,
  input wire logic [7:0] i_rx_options,
  input wire logic [15:0] i_rx_pay_len,
  // Command response request
  input wire logic i_at_start,
  input wire logic [7:0] i_at_req_type,
  input wire logic [7:0] i_at_frame_id,
  input wire logic [15:0] i_at_command,
  input wire logic [1:0] i_at_status,
  input wire logic i_at_is_query,
  input wire logic [15:0] i_at_data_len,
  // Payload pull port, shared by both frame kinds
  output logic o_pay_req,
  input wire logic i_pay_valid,
  input wire logic [7:0] i_pay_data,
  // Byte stream towards the host
  output logic [7:0] o_tx_data,
  output logic o_tx_valid,
  input wire logic i_tx_ready,
  // Status
  output logic o_idle,
  output logic o_dropped
);

  // ****************************************************************
  // Functions
  // ****************************************************************

  // Byte n of a 64-bit field, counted from the most significant end
  // Only the low three bits of n count; callers stay inside the field
  function automatic logic [7:0] msb_byte(input logic [63:0] value, input logic [4:0] n);
    logic [63:0] shifted;
    shifted = value >> (7'(7 - n[2:0]) * 7'd8);
    return shifted[7:0];
  endfunction

  // ****************************************************************
  // Declarations
  // ****************************************************************
  arf_pkg::arf_state_t state; // Sequencer state
  arf_pkg::arf_state_t next_state; // Its next value
  logic kind_rx; // High: receive frame, low: command response
  logic [63:0] src_addr; // Captured sender address
  logic [7:0] rssi; // Captured strength byte
  logic [7:0] options; // Captured option bits
  logic [7:0] frame_id; // Captured request id
  logic [15:0] command; // Captured command characters
  logic [1:0] status; // Captured status code
  logic [15:0] frame_len; // Value of the length field
  logic [15:0] pay_left; // Payload bytes still owed
  logic [4:0] idx; // Offset of the next header byte
  logic [7:0] sum; // Running byte sum from type on
  logic pay_pending; // A pull is out, byte not yet back

  // ****************************************************************
  // Request decode
  // ****************************************************************

  // Receive frames only in legacy output mode from a long-addressed sender
  wire rx_wanted = (i_api_output_option == arf_pkg::OUTPUT_OPTION_LEGACY) &&
                   (i_rx_own_short_address == arf_pkg::SHORT_ADDR_NONE);
  // Responses only for a local request with a nonzero id
  wire at_type_ok = (i_at_req_type == arf_pkg::TYPE_AT_REQ) ||
                    (i_at_req_type == arf_pkg::TYPE_AT_QUEUED);
  wire at_wanted = at_type_ok && (i_at_frame_id != arf_pkg::BYTE_RESET);
  // A refused request is still taken, so it cannot start a later frame
  // Receive wins when both arrive together
  wire take_rx = o_idle && i_rx_start;
  wire take_at = o_idle && i_at_start && !i_rx_start;
  wire start_rx = take_rx && rx_wanted;
  wire start_at = take_at && at_wanted;
  wire drop_now = (take_rx && !rx_wanted) || (take_at && !at_wanted);
  // Parameter writes carry no data
  wire [15:0] at_pay = i_at_is_query ? i_at_data_len : arf_pkg::COUNT_RESET;

  // ****************************************************************
  // Header byte selection
  // ****************************************************************
  // Offsets 0 to 2 are common; the rest depends on the frame kind
  wire [4:0] head_last = kind_rx ? arf_pkg::OFS_OPTIONS : arf_pkg::OFS_STATUS;
  wire [7:0] rx_head_byte =
    (idx == arf_pkg::OFS_TYPE) ? arf_pkg::TYPE_RX64 :
    (idx <= arf_pkg::OFS_SRC_LAST) ? msb_byte(src_addr, idx - arf_pkg::OFS_SRC_FIRST) :
    (idx == arf_pkg::OFS_RSSI) ? rssi :
    options;
  wire [7:0] at_head_byte =
    (idx == arf_pkg::OFS_TYPE) ? arf_pkg::TYPE_AT_RESP :
    (idx == arf_pkg::OFS_FRAME_ID) ? frame_id :
    (idx == arf_pkg::OFS_CMD_HI) ? command[15:8] :
    (idx == arf_pkg::OFS_CMD_LO) ? command[7:0] :
    {6'h00, status};
  wire [7:0] head_byte =
    (idx == arf_pkg::IDX_RESET) ? arf_pkg::START_DELIM :
    (idx == arf_pkg::OFS_LEN_HI) ? frame_len[15:8] :
    (idx == arf_pkg::OFS_LEN_LO) ? frame_len[7:0] :
    kind_rx ? rx_head_byte : at_head_byte;
  wire head_summed = (idx >= arf_pkg::OFS_TYPE);

  // ****************************************************************
  // Output slot handshakes
  // ****************************************************************
  // Slot counts as free when empty or emptied at this edge, so header
  // bytes follow each other at the full host rate
  wire slot_free = !o_tx_valid || i_tx_ready;
  wire head_go = (state == arf_pkg::ST_HEAD) && slot_free;
  // Pull only into an empty slot, so the returning byte always fits
  wire pull_go = (state == arf_pkg::ST_PAYLOAD) && !o_tx_valid && !pay_pending && !o_pay_req;
  wire pay_in = (state == arf_pkg::ST_PAYLOAD) && pay_pending && i_pay_valid;
  wire sum_go = (state == arf_pkg::ST_SUM) && slot_free;
  wire pay_last = (pay_left == 16'h0001);

  // ****************************************************************
  // Next state
  // ****************************************************************

  // Header, then payload if any, then checksum
  always_comb begin
    next_state = state;
    case (state)
      arf_pkg::ST_IDLE: begin
        if (start_rx || start_at) begin
          next_state = arf_pkg::ST_HEAD;
        end
      end
      arf_pkg::ST_HEAD: begin
        if (head_go && (idx == head_last)) begin
          // Empty payload goes straight to the checksum
          next_state = (pay_left == arf_pkg::COUNT_RESET) ? arf_pkg::ST_SUM : arf_pkg::ST_PAYLOAD;
        end
      end
      arf_pkg::ST_PAYLOAD: begin
        if (pay_in && pay_last) begin
          next_state = arf_pkg::ST_SUM;
        end
      end
      arf_pkg::ST_SUM: begin
        // Idle may return while the checksum still waits in the slot
        if (sum_go) begin
          next_state = arf_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = arf_pkg::ST_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // Sequencer registers
  // ****************************************************************

  // State and idle flag
  // Idle is a register so the start gates see a settled level
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      state <= arf_pkg::ST_IDLE;
      o_idle <= 1'b1;
    end else begin
      state <= next_state;
      o_idle <= (next_state == arf_pkg::ST_IDLE);
    end
  end

  // Request capture; a later request with the same id simply yields one more frame
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      kind_rx <= 1'b0;
      src_addr <= 64'h0000000000000000;
      rssi <= arf_pkg::BYTE_RESET;
      options <= arf_pkg::BYTE_RESET;
      frame_id <= arf_pkg::BYTE_RESET;
      command <= arf_pkg::COUNT_RESET;
      status <= arf_pkg::STATUS_OK;
      frame_len <= arf_pkg::COUNT_RESET;
    end else if (start_rx) begin
      kind_rx <= 1'b1;
      src_addr <= i_rx_src_addr;
      rssi <= i_rx_rssi;
      options <= i_rx_options;
      frame_len <= arf_pkg::RX_FIXED_LEN + i_rx_pay_len;
    end else if (start_at) begin
      kind_rx <= 1'b0;
      frame_id <= i_at_frame_id;
      command <= i_at_command;
      status <= i_at_status;
      frame_len <= arf_pkg::AT_FIXED_LEN + at_pay;
    end
  end

  // Header offset counter
  always_ff @(posedge i_clock) begin
    if (!i_reset_n || (state == arf_pkg::ST_IDLE)) begin
      idx <= arf_pkg::IDX_RESET;
    end else if (head_go) begin
      idx <= idx + 5'h01;
    end
  end

  // Payload bytes still owed
  // Header bytes are counted by the offset counter instead
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      pay_left <= arf_pkg::COUNT_RESET;
    end else if (start_rx) begin
      pay_left <= i_rx_pay_len;
    end else if (start_at) begin
      pay_left <= at_pay;
    end else if (pay_in) begin
      pay_left <= pay_left - 16'h0001;
    end
  end

  // Pull strobe, one cycle, and the wait for its byte
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_pay_req <= 1'b0;
      pay_pending <= 1'b0;
    end else begin
      o_pay_req <= pull_go;
      // A byte with no pull out is ignored
      pay_pending <= (pay_pending && !pay_in) || o_pay_req;
    end
  end

  // Running sum of every byte from the type on
  // Start, length and checksum bytes stay out of it
  always_ff @(posedge i_clock) begin
    if (!i_reset_n || (state == arf_pkg::ST_IDLE)) begin
      sum <= arf_pkg::BYTE_RESET;
    end else if (head_go && head_summed) begin
      sum <= sum + head_byte;
    end else if (pay_in) begin
      sum <= sum + i_pay_data;
    end
  end

  // ****************************************************************
  // Output byte register
  // ****************************************************************

  // One byte at a time; held until the host takes it
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_tx_data <= arf_pkg::BYTE_RESET;
      o_tx_valid <= 1'b0;
    end else if (head_go) begin
      o_tx_data <= head_byte;
      o_tx_valid <= 1'b1;
    end else if (pay_in) begin
      o_tx_data <= i_pay_data;
      o_tx_valid <= 1'b1;
    end else if (sum_go) begin
      o_tx_data <= arf_pkg::SUM_SEED - sum;
      o_tx_valid <= 1'b1;
    end else if (i_tx_ready) begin
      // Taken with nothing new to load, so the slot empties
      o_tx_valid <= 1'b0;
    end
  end

  // Suppressed request, reported for one cycle
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_dropped <= 1'b0;
    end else begin
      o_dropped <= drop_now;
    end
  end

endmodule // arf_framer

// ===== test/arf_framer_assertions.sv
/*
  Port checks for the API output framer.
  Assumes one clock and a synchronous active-low reset.
*/
// ******************************
// Framer port checker
// ******************************
module arf_framer_assertions (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic [7:0] i_api_output_option,
  input wire logic i_rx_start,
  input wire logic [15:0] i_rx_own_short_address,
  input wire logic i_at_start,
  input wire logic [7:0] i_at_req_type,
  input wire logic [7:0] i_at_frame_id,
  input wire logic o_pay_req,
  input wire logic [7:0] o_tx_data,
  input wire logic o_tx_valid,
  input wire logic i_tx_ready,
  input wire logic o_idle,
  input wire logic o_dropped
);
  timeunit 1ns;
  timeprecision 1ns;
  // One domain, so one clock and reset for all
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  // Receive request passes both gates
  wire rx_ok = i_api_output_option == 8'h02 && i_rx_own_short_address == 16'hFFFE;
  // Response request of a known kind with a live id
  wire at_ok = (i_at_req_type == 8'h08 || i_at_req_type == 8'h09) && i_at_frame_id != 8'h00;
  a_rx_taken: assert property (o_idle && !o_tx_valid && i_rx_start && rx_ok |=> !o_idle ##1
    (o_tx_valid && o_tx_data == 8'h7E))
    else $error("receive request not framed");
  a_rx_refused: assert property (o_idle && i_rx_start && !rx_ok |=> o_dropped && o_idle)
    else $error("gated receive request not dropped");
  a_at_taken: assert property (o_idle && !o_tx_valid && !i_rx_start && i_at_start && at_ok |=>
    !o_dropped && !o_idle ##1 (o_tx_valid && o_tx_data == 8'h7E))
    else $error("command response not started");
  a_at_refused: assert property (o_idle && !i_rx_start && i_at_start && !at_ok |=> o_dropped && o_idle)
    else $error("bad command response request not dropped");
  a_zero_id: assert property (o_idle && !i_rx_start && i_at_start && i_at_frame_id == 8'h00 |=> o_dropped)
    else $error("zero id response not dropped");
  a_drop_quiet: assert property (o_dropped |-> o_idle && !$rose(o_tx_valid) && !o_pay_req)
    else $error("dropped request made traffic");
  a_byte_hold: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
    else $error("output byte changed while stalled");
  a_type_byte: assert property ($fell(o_idle) ##1 (o_tx_valid && i_tx_ready) [*3]
    |=> o_tx_data == 8'h80 || o_tx_data == 8'h88)
    else $error("frame type byte not at offset three");
  a_pull_pulse: assert property (o_pay_req |=> !o_pay_req)
    else $error("pull strobe longer than one cycle");
endmodule // arf_framer_assertions

bind arf_framer arf_framer_assertions chk (.i_clock, .i_reset_n, .i_api_output_option, .i_rx_start,
  .i_rx_own_short_address, .i_at_start, .i_at_req_type, .i_at_frame_id, .o_pay_req, .o_tx_data,
  .o_tx_valid, .i_tx_ready, .o_idle, .o_dropped);

// ===== test/arf_host_model.sv
/*
  Host side of the framer: takes output bytes, stalling on request,
  and serves payload bytes after a pull. Assumes the bench fills pay_q.
*/
// ******************************
// Host and payload source model
// ******************************
module arf_host_model (
  input wire logic i_clock,
  input wire logic i_slow,
  input wire logic [7:0] i_tx_data,
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  input wire logic i_pay_req,
  output logic o_pay_valid,
  output logic [7:0] o_pay_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got[$]; // Bytes taken from the stream
  logic [7:0] pay_q[$]; // Payload still to hand out
  logic [1:0] cnt = 2'h0; // Pull round trip countdown
  initial begin
    o_tx_ready = 1'h1;
    o_pay_valid = 1'h0;
    o_pay_data = 8'h00;
  end
  // Slow host halves its rate, so header bytes also meet stalls
  always @(posedge i_clock) begin
    o_tx_ready <= i_slow ? ~o_tx_ready : 1'h1;
    if (i_tx_valid && o_tx_ready) begin
      got.push_back(i_tx_data);
    end
    cnt <= i_pay_req ? (i_slow ? 2'h3 : 2'h1) : (cnt != 2'h0 ? cnt - 2'h1 : cnt);
    o_pay_valid <= cnt == 2'h1;
    // Idle data line toggles, so a stale byte cannot pass
    if (cnt == 2'h1) begin
      o_pay_data <= pay_q.pop_front();
    end else begin
      o_pay_data <= ~o_pay_data;
    end
  end
endmodule // arf_host_model

// ===== test/arf_framer_bench.sv
/*
  Self-checking bench of the API output framer.
  Assumes the checker is bound and the host model sits beside it.
*/
// ******************************
// Framer bench
// ******************************
module arf_framer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef logic [7:0] arf_bq_t[$];
  logic i_clock = 1'h0, i_reset_n = 1'h0, slow = 1'h0;
  logic i_rx_start = 1'h0, i_at_start = 1'h0, i_at_is_query = 1'h0;
  logic [7:0] i_api_output_option = 8'h02, i_rx_rssi = 8'h00, i_rx_options = 8'h00;
  logic [7:0] i_at_req_type = 8'h08, i_at_frame_id = 8'h00;
  logic [15:0] i_rx_own_short_address = 16'hFFFE, i_rx_pay_len = 16'h0000;
  logic [15:0] i_at_command = 16'h0000, i_at_data_len = 16'h0000;
  logic [63:0] i_rx_src_addr = 64'h0;
  logic [1:0] i_at_status = 2'h0;
  wire o_pay_req, i_pay_valid, o_tx_valid, i_tx_ready, o_idle, o_dropped;
  wire [7:0] i_pay_data, o_tx_data;
  int error_cnt = 0, checked = 0, j;
  arf_bq_t exp; // Bytes the next frame should carry
  `define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
  always #50 i_clock = ~i_clock;
  arf_framer dut (.*);
  arf_host_model host (.i_clock(i_clock), .i_slow(slow), .i_tx_data(o_tx_data), .i_tx_valid(o_tx_valid),
    .o_tx_ready(i_tx_ready), .i_pay_req(o_pay_req), .o_pay_valid(i_pay_valid), .o_pay_data(i_pay_data));
  // Wrap body bytes with start, length and checksum
  function automatic arf_bq_t frame(arf_bq_t b);
    logic [7:0] s;
    logic [15:0] n;
    s = 8'h00;
    n = 16'(b.size());
    foreach (b[i]) s += b[i];
    return {8'h7E, n[15:8], n[7:0], b, 8'hFF - s};
  endfunction
  task give_verdict;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Take the request, then wait for the stream to drain
  task go(input logic drop);
    int k;
    @(posedge i_clock);
    i_rx_start <= 1'h0;
    i_at_start <= 1'h0;
    #1;
    `CHK(o_dropped, drop)
    if (drop) exp.delete();
    for (k = 0; k < 500 && (!o_idle || o_tx_valid); k++) begin
      @(posedge i_clock);
      #1;
    end
    if (k == 500) begin
      $display("MISMATCH %0t frame did not finish", $time);
      error_cnt++;
      give_verdict;
    end
    `CHK(host.got.size(), exp.size())
    foreach (exp[i]) `CHK(host.got[i], exp[i])
  endtask
  // Payload bytes shared by both kinds; known pattern
  task pay(input int n);
    int i;
    host.pay_q.delete();
    host.got.delete();
    for (i = 0; i < n; i++) begin
      host.pay_q.push_back(8'(8'hC3 + i * 7));
      exp.push_back(host.pay_q[i]);
    end
    exp = frame(exp);
  endtask
  task rx_req(input logic [7:0] m, r, o, input logic [15:0] sh, input logic [63:0] a, input int n, input logic d);
    int i;
    exp = {8'h80};
    for (i = 7; i >= 0; i--) exp.push_back(a[i*8+:8]);
    exp.push_back(r);
    exp.push_back(o);
    pay(n);
    @(posedge i_clock);
    i_api_output_option <= m;
    i_rx_rssi <= r;
    i_rx_options <= o;
    i_rx_own_short_address <= sh;
    i_rx_src_addr <= a;
    i_rx_pay_len <= 16'(n);
    i_rx_start <= 1'h1;
    go(d);
  endtask
  task at_req(input logic [7:0] t, id, input logic [15:0] c, input logic [1:0] s, input int n, input logic d);
    exp = {8'h88, id, c[15:8], c[7:0], 8'(s)};
    pay(n);
    @(posedge i_clock);
    i_at_req_type <= t;
    i_at_frame_id <= id;
    i_at_command <= c;
    i_at_status <= s;
    i_at_is_query <= n != 0;
    i_at_data_len <= 16'(n);
    i_at_start <= 1'h1;
    go(d);
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge i_clock);
    i_reset_n <= 1'h1;
    at_req(8'h08, 8'h01, 16'h4E49, 2'h0, 0, 1'h0);
    $display("test write reply done");
    slow = 1'h1;
    at_req(8'h09, 8'h17, 16'h5450, 2'h0, 2, 1'h0);
    for (j = 0; j < 4; j++) at_req(8'h08, 8'h52, 16'h4E44, j[1:0], j, 1'h0);
    $display("test query replies done");
    rx_req(8'h02, 8'h28, 8'h06, 16'hFFFE, 64'h0013A20087654321, 6, 1'h0);
    slow = 1'h0;
    rx_req(8'h02, 8'h5E, 8'h01, 16'hFFFE, 64'hFEDCBA9876543210, 0, 1'h0);
    $display("test receive frames done");
    rx_req(8'h01, 8'h28, 8'h00, 16'hFFFE, 64'h1, 3, 1'h1);
    rx_req(8'h02, 8'h28, 8'h00, 16'h1234, 64'h1, 3, 1'h1);
    at_req(8'h08, 8'h00, 16'h4E49, 2'h0, 0, 1'h1);
    at_req(8'h17, 8'h05, 16'h4E49, 2'h0, 0, 1'h1);
    at_req(8'h08, 8'hFF, 16'h4944, 2'h3, 1, 1'h0);
    $display("test refusals done");
    give_verdict;
  end
endmodule // arf_framer_bench
